// [core/jtbs_pkg.sv]
package jtbs_pkg;

  // ==========================================================
  // tap controller states
  typedef enum logic [3:0] {
    JTBS_TLR       = 4'h0,
    JTBS_RTI       = 4'h1,
    JTBS_SEL_DR    = 4'h2,
    JTBS_CAP_DR    = 4'h3,
    JTBS_SHIFT_DR  = 4'h4,
    JTBS_EXIT1_DR  = 4'h5,
    JTBS_PAUSE_DR  = 4'h6,
    JTBS_EXIT2_DR  = 4'h7,
    JTBS_UPD_DR    = 4'h8,
    JTBS_SEL_IR    = 4'h9,
    JTBS_CAP_IR    = 4'ha,
    JTBS_SHIFT_IR  = 4'hb,
    JTBS_EXIT1_IR  = 4'hc,
    JTBS_PAUSE_IR  = 4'hd,
    JTBS_EXIT2_IR  = 4'he,
    JTBS_UPD_IR    = 4'hf
  } jtbs_tap_state_e;

  // ==========================================================
  // instruction codes
  localparam int IR_LEN = 3;
  localparam logic [2:0] INSN_EXTEST = 3'h0;
  localparam logic [2:0] INSN_SAMPLE = 3'h1;
  localparam logic [2:0] INSN_RSVD_2 = 3'h2;
  localparam logic [2:0] INSN_RSVD_3 = 3'h3;
  localparam logic [2:0] INSN_RSVD_4 = 3'h4;
  localparam logic [2:0] INSN_TRISTATE = 3'h5;
  localparam logic [2:0] INSN_CONTINUITY = 3'h6;
  localparam logic [2:0] INSN_BYPASS = 3'h7;
  localparam logic [2:0] IR_RESET_VALUE = INSN_BYPASS;
  // fixed capture pattern, low two bits 01 as customary
  localparam logic [2:0] IR_CAPTURE_VALUE = 3'h1;
  localparam logic BYPASS_CAPTURE_VALUE = 1'b0;
  localparam logic BYPASS_RESET_VALUE = 1'b0;

  // ==========================================================
  // boundary chain, cell 0 sits next to test data in
  localparam int BSR_LEN = 75;
  localparam int CELL_INT = 0;
  localparam int CELL_AD_OE = 5;
  localparam int CELL_CBE_OE = 14;
  localparam int CELL_FRAME_OE = 26;
  localparam int CELL_IRDY_OE = 28;
  localparam int CELL_TRDY_OE = 30;
  localparam int CELL_DEVSEL_OE = 32;
  localparam int CELL_STOP_OE = 34;
  localparam int CELL_PERR_OE = 36;
  localparam int CELL_PAR_OE = 39;
  localparam int CELL_SERIAL_ROM_OUT = 59;
  localparam int CELL_SERIAL_ROM_IN = 60;
  localparam int CELL_SERIAL_ROM_CLOCK = 61;
  localparam int CELL_SERIAL_ROM_SELECT = 62;
  localparam int CELL_ROM_PORT_DATA_0 = 63;
  localparam int CELL_ROM_PORT_DATA_OE = 69;
  localparam int CELL_ROM_PORT_DATA_6 = 70;
  localparam int CELL_ROM_PORT_CHIP_ENABLE_N = 72;
  localparam int CELL_ROM_PORT_ADDR_LINE_0 = 73;
  localparam int CELL_ROM_PORT_ADDR_LINE_1 = 74;
  localparam logic [BSR_LEN-1:0] BSR_RESET_VALUE = '0;

  // ==========================================================
  // cell kinds
  function automatic logic jtbs_is_enable_cell(input int idx);
    return (idx == CELL_AD_OE) || (idx == CELL_CBE_OE) ||
      (idx == CELL_FRAME_OE) || (idx == CELL_IRDY_OE) ||
      (idx == CELL_TRDY_OE) || (idx == CELL_DEVSEL_OE) ||
      (idx == CELL_STOP_OE) || (idx == CELL_PERR_OE) ||
      (idx == CELL_PAR_OE) || (idx == CELL_ROM_PORT_DATA_OE);
  endfunction

  // interrupt, pci and serial rom pads are the ones that float in tristate mode
  function automatic logic jtbs_is_float_cell(input int idx);
    return idx <= CELL_SERIAL_ROM_SELECT;
  endfunction

endpackage

// [core/jtbs_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module jtbs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // ==========================================================
  // two flop synchroniser, stage1 feeds only the second flop
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule
`default_nettype wire

// [core/jtbs_tap_fsm.sv]
`timescale 1ns/1ps
`default_nettype none
module jtbs_tap_fsm (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic step_in,
  input wire logic tms_in,
  output jtbs_pkg::jtbs_tap_state_e state_out
);

  jtbs_pkg::jtbs_tap_state_e next_state;

  // ==========================================================
  // standard sixteen state walk
  always_comb begin
    next_state = state_out;
    case (state_out)
      jtbs_pkg::JTBS_TLR: begin
        next_state = tms_in ? jtbs_pkg::JTBS_TLR : jtbs_pkg::JTBS_RTI;
      end
      jtbs_pkg::JTBS_RTI: begin
        next_state = tms_in ? jtbs_pkg::JTBS_SEL_DR : jtbs_pkg::JTBS_RTI;
      end
      jtbs_pkg::JTBS_SEL_DR: begin
        next_state = tms_in ? jtbs_pkg::JTBS_SEL_IR :
          jtbs_pkg::JTBS_CAP_DR;
      end
      jtbs_pkg::JTBS_CAP_DR, jtbs_pkg::JTBS_SHIFT_DR,
      jtbs_pkg::JTBS_EXIT2_DR: begin
        next_state = tms_in ? jtbs_pkg::JTBS_EXIT1_DR :
          jtbs_pkg::JTBS_SHIFT_DR;
        if (state_out == jtbs_pkg::JTBS_EXIT2_DR && tms_in) begin
          next_state = jtbs_pkg::JTBS_UPD_DR;
        end
      end
      jtbs_pkg::JTBS_EXIT1_DR: begin
        next_state = tms_in ? jtbs_pkg::JTBS_UPD_DR :
          jtbs_pkg::JTBS_PAUSE_DR;
      end
      jtbs_pkg::JTBS_PAUSE_DR: begin
        next_state = tms_in ? jtbs_pkg::JTBS_EXIT2_DR :
          jtbs_pkg::JTBS_PAUSE_DR;
      end
      jtbs_pkg::JTBS_UPD_DR, jtbs_pkg::JTBS_UPD_IR: begin
        next_state = tms_in ? jtbs_pkg::JTBS_SEL_DR : jtbs_pkg::JTBS_RTI;
      end
      jtbs_pkg::JTBS_SEL_IR: begin
        next_state = tms_in ? jtbs_pkg::JTBS_TLR : jtbs_pkg::JTBS_CAP_IR;
      end
      jtbs_pkg::JTBS_CAP_IR, jtbs_pkg::JTBS_SHIFT_IR,
      jtbs_pkg::JTBS_EXIT2_IR: begin
        next_state = tms_in ? jtbs_pkg::JTBS_EXIT1_IR :
          jtbs_pkg::JTBS_SHIFT_IR;
        if (state_out == jtbs_pkg::JTBS_EXIT2_IR && tms_in) begin
          next_state = jtbs_pkg::JTBS_UPD_IR;
        end
      end
      jtbs_pkg::JTBS_EXIT1_IR: begin
        next_state = tms_in ? jtbs_pkg::JTBS_UPD_IR :
          jtbs_pkg::JTBS_PAUSE_IR;
      end
      jtbs_pkg::JTBS_PAUSE_IR: begin
        next_state = tms_in ? jtbs_pkg::JTBS_EXIT2_IR :
          jtbs_pkg::JTBS_PAUSE_IR;
      end
      default: begin
        next_state = jtbs_pkg::JTBS_TLR;
      end
    endcase
  end

  // advance only on a test clock rising edge
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      state_out <= jtbs_pkg::JTBS_TLR;
    end else if (step_in) begin
      state_out <= next_state;
    end
  end

endmodule
`default_nettype wire

// [core/jtbs_top.sv]
// Overview of operation
// - full standard tap state machine stepped by tms on test clock.
// - three bit instruction register shifted between tdi and tdo.
// - code 000 drives boundary update data onto the output pins.
// - code 001 preloads cells and samples pins without disturbing system.
// - code 110 selects production continuity test mode.
// - code 111 places bypass register alone between tdi and tdo.
// - power-up reset loads bypass instruction with no controller action.
// - bypass register is one stage, used when no other register selected.
// - in external test every cell drives its own pin; enable cells gate no outputs.
// - chain runs interrupt, pci control, pci bus, serial rom, rom port.
// - rom port data enable between bits 5 and 6, chip enable before addr.
`timescale 1ns/1ps
`default_nettype none
module jtbs_top (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_n_out,
  input wire logic [jtbs_pkg::BSR_LEN-1:0] core_out_in,
  input wire logic [jtbs_pkg::BSR_LEN-1:0] pin_in,
  output logic [jtbs_pkg::BSR_LEN-1:0] pin_out,
  output logic [jtbs_pkg::BSR_LEN-1:0] pad_hiz_out,
  output logic extest_active_out,
  output logic continuity_mode_out,
  output logic [2:0] test_instruction_out,
  output logic [3:0] tap_state_out
);

  localparam int SYNC_W = jtbs_pkg::BSR_LEN + 3;

  // ==========================================================
  // input synchronisation
  logic [SYNC_W-1:0] sync_q;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic [jtbs_pkg::BSR_LEN-1:0] pin_s;

  jtbs_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .async_in({pin_in, tdi_in, tms_in, tck_in}),
    .sync_out(sync_q)
  );

  assign tck_s = sync_q[0];
  assign tms_s = sync_q[1];
  assign tdi_s = sync_q[2];
  assign pin_s = sync_q[SYNC_W-1:3];

  // ==========================================================
  // test clock edge detection
  logic tck_prev;
  logic tck_rise;
  logic tck_fall;

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      tck_prev <= 1'b0;
    end else begin
      tck_prev <= tck_s;
    end
  end

  assign tck_rise = tck_s & ~tck_prev;
  assign tck_fall = ~tck_s & tck_prev;

  // ==========================================================
  // tap controller
  jtbs_pkg::jtbs_tap_state_e tap_state;

  jtbs_tap_fsm u_fsm (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .step_in(tck_rise),
    .tms_in(tms_s),
    .state_out(tap_state)
  );

  assign tap_state_out = tap_state;

  logic in_tlr;
  logic in_cap_dr;
  logic in_shift_dr;
  logic in_upd_dr;
  logic in_cap_ir;
  logic in_shift_ir;
  logic in_upd_ir;

  assign in_tlr = (tap_state == jtbs_pkg::JTBS_TLR);
  assign in_cap_dr = (tap_state == jtbs_pkg::JTBS_CAP_DR);
  assign in_shift_dr = (tap_state == jtbs_pkg::JTBS_SHIFT_DR);
  assign in_upd_dr = (tap_state == jtbs_pkg::JTBS_UPD_DR);
  assign in_cap_ir = (tap_state == jtbs_pkg::JTBS_CAP_IR);
  assign in_shift_ir = (tap_state == jtbs_pkg::JTBS_SHIFT_IR);
  assign in_upd_ir = (tap_state == jtbs_pkg::JTBS_UPD_IR);

  // ==========================================================
  // instruction register
  logic [2:0] ir_shift;
  logic [2:0] test_instruction_reg;

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      ir_shift <= jtbs_pkg::IR_RESET_VALUE;
    end else if (tck_rise && in_cap_ir) begin
      ir_shift <= jtbs_pkg::IR_CAPTURE_VALUE;
    end else if (tck_rise && in_shift_ir) begin
      ir_shift <= {tdi_s, ir_shift[2:1]};
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      test_instruction_reg <= jtbs_pkg::IR_RESET_VALUE;
    end else if (in_tlr) begin
      test_instruction_reg <= jtbs_pkg::IR_RESET_VALUE;
    end else if (tck_fall && in_upd_ir) begin
      test_instruction_reg <= ir_shift;
    end
  end

  assign test_instruction_out = test_instruction_reg;

  // ==========================================================
  // instruction decode
  logic sel_bsr;
  logic next_extest;
  logic next_tristate;
  logic next_continuity;

  always_comb begin
    sel_bsr = 1'b0;
    next_extest = 1'b0;
    next_tristate = 1'b0;
    next_continuity = 1'b0;
    case (test_instruction_reg)
      jtbs_pkg::INSN_EXTEST: begin
        sel_bsr = 1'b1;
        next_extest = 1'b1;
      end
      jtbs_pkg::INSN_SAMPLE: begin
        sel_bsr = 1'b1;
      end
      jtbs_pkg::INSN_TRISTATE: begin
        next_tristate = 1'b1;
      end
      jtbs_pkg::INSN_CONTINUITY: begin
        next_continuity = 1'b1;
      end
      jtbs_pkg::INSN_BYPASS: begin
        sel_bsr = 1'b0;
      end
      default: begin
        sel_bsr = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // mode flags, held in flip-flops one clock behind the instruction
  logic mode_extest;
  logic mode_tristate;
  logic mode_continuity;

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      mode_extest <= 1'b0;
    end else begin
      mode_extest <= next_extest;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      mode_tristate <= 1'b0;
    end else begin
      mode_tristate <= next_tristate;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      mode_continuity <= 1'b0;
    end else begin
      mode_continuity <= next_continuity;
    end
  end

  assign extest_active_out = mode_extest;
  assign continuity_mode_out = mode_continuity;

  // ==========================================================
  // bypass register
  logic bypass_reg;

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      bypass_reg <= jtbs_pkg::BYPASS_RESET_VALUE;
    end else if (tck_rise && in_cap_dr && !sel_bsr) begin
      bypass_reg <= jtbs_pkg::BYPASS_CAPTURE_VALUE;
    end else if (tck_rise && in_shift_dr && !sel_bsr) begin
      bypass_reg <= tdi_s;
    end
  end

  // ==========================================================
  // boundary scan register
  logic [jtbs_pkg::BSR_LEN-1:0] bsr_shift;
  logic [jtbs_pkg::BSR_LEN-1:0] bsr_update;

  // cell 0 nearest tdi, last cell feeds tdo
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      bsr_shift <= jtbs_pkg::BSR_RESET_VALUE;
    end else if (tck_rise && in_cap_dr && sel_bsr) begin
      bsr_shift <= pin_s;
    end else if (tck_rise && in_shift_dr && sel_bsr) begin
      bsr_shift <= {bsr_shift[jtbs_pkg::BSR_LEN-2:0], tdi_s};
    end
  end

  // preload holds until another instruction uses it
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      bsr_update <= jtbs_pkg::BSR_RESET_VALUE;
    end else if (tck_fall && in_upd_dr && sel_bsr) begin
      bsr_update <= bsr_shift;
    end
  end

  // ==========================================================
  // test data out
  logic tdo_next;

  always_comb begin
    tdo_next = bypass_reg;
    if (in_shift_ir) begin
      tdo_next = ir_shift[0];
    end else if (sel_bsr) begin
      tdo_next = bsr_shift[jtbs_pkg::BSR_LEN-1];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      tdo_out <= 1'b0;
    end else if (tck_fall) begin
      tdo_out <= tdo_next;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      tdo_oe_n_out <= 1'b1;
    end else if (tck_fall) begin
      tdo_oe_n_out <= ~(in_shift_dr | in_shift_ir);
    end
  end

  // ==========================================================
  // pad ring multiplexers
  genvar gi;
  generate
    for (gi = 0; gi < jtbs_pkg::BSR_LEN; gi++) begin : g_cell
      localparam logic IS_FLOAT = jtbs_pkg::jtbs_is_float_cell(gi);

      // enable and data cells drive pins in external test
      // otherwise the functional value passes untouched
      assign pin_out[gi] = mode_extest ? bsr_update[gi] : core_out_in[gi];

      if (IS_FLOAT) begin : g_float
        assign pad_hiz_out[gi] = mode_tristate;
      end else begin : g_keep
        assign pad_hiz_out[gi] = 1'b0;
      end
    end
  endgenerate

endmodule
`default_nettype wire

// [verif/jtbs_top_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module jtbs_chk (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  input wire logic tdo_out,
  input wire logic tdo_oe_n_out,
  input wire logic [74:0] core_out_in,
  input wire logic [74:0] pin_in,
  input wire logic [74:0] pin_out,
  input wire logic [74:0] pad_hiz_out,
  input wire logic extest_active_out,
  input wire logic continuity_mode_out,
  input wire logic [2:0] test_instruction_out,
  input wire logic [3:0] tap_state_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_b_in);
  // ====
  // assertions
  AST_PIN_FUNC: assert property (
    !extest_active_out |-> pin_out == core_out_in)
    else $error("pins leave functional path");
  AST_EXT_DECODE: assert property (
    extest_active_out == ($past(test_instruction_out) == 3'h0))
    else $error("extest flag wrong");
  AST_CONT_DECODE: assert property (
    continuity_mode_out == ($past(test_instruction_out) == 3'h6))
    else $error("continuity flag wrong");
  AST_HIZ: assert property (
    pad_hiz_out == (($past(test_instruction_out) == 3'h5) ?
    {12'h000, {63{1'b1}}} : 75'h0))
    else $error("float pattern wrong");
  AST_TLR_BYP: assert property (
    tap_state_out == 4'h0 |=> test_instruction_out == 3'h7)
    else $error("reset state without bypass");
  AST_OE_SHIFT: assert property (
    $fell(tdo_oe_n_out) |-> tap_state_out inside {4'h4, 4'hb})
    else $error("tdo driven outside shift");
  AST_OE_IDLE: assert property (
    tap_state_out inside {4'h0, 4'h1} |-> tdo_oe_n_out)
    else $error("tdo driven while idle");
  AST_TDO_FALL: assert property (
    $changed(tdo_out) |-> !tck_in && !$past(tck_in))
    else $error("tdo moved while tck high");
  AST_IR_UPD: assert property (
    $changed(test_instruction_out) |->
    $past(tap_state_out) inside {4'h0, 4'hf})
    else $error("instruction changed outside update");
  AST_STEP: assert property (
    $rose(tck_in) && tms_in && tap_state_out == 4'h1 |->
    ##[2:5] tap_state_out == 4'h2)
    else $error("tap did not step");
  cover property (tap_state_out == 4'hf);
  cover property (extest_active_out);
  cover property (test_instruction_out == 3'h5);
  cover property ($fell(tdo_oe_n_out));
endmodule
bind jtbs_top jtbs_chk u_chk (.clock_in, .rst_b_in, .tck_in, .tms_in,
  .tdi_in, .tdo_out, .tdo_oe_n_out, .core_out_in, .pin_in, .pin_out,
  .pad_hiz_out, .extest_active_out, .continuity_mode_out,
  .test_instruction_out, .tap_state_out);
`default_nettype wire

// [verif/jtbs_tap_host.sv]
`timescale 1ns/1ps
`default_nettype none
module jtbs_tap_host (
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  input wire logic tdo_in,
  input wire logic tdo_oe_n_in
);
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
  end
  // ====
  // one tck period, tck rests low between frames
  task automatic pulse(input logic tms, input logic tdi, output logic tdo);
    tms_out = tms;
    tdi_out = tdi;
    #100;
    tdo = tdo_oe_n_in ? 1'bx : tdo_in;
    tck_out = 1'b1;
    #100;
    tck_out = 1'b0;
  endtask
  task automatic to_idle();
    logic t;
    #7;
    repeat (5) pulse(1'b1, ~tdi_out, t);
    pulse(1'b0, ~tdi_out, t);
  endtask
  // scan from idle back to idle, lsb first
  task automatic scan(input logic ir, input int n, input logic [74:0] din,
                      output logic [74:0] dout);
    logic t;
    dout = '0;
    #7;
    pulse(1'b1, ~tdi_out, t);
    if (ir) pulse(1'b1, ~tdi_out, t);
    pulse(1'b0, ~tdi_out, t);
    pulse(1'b0, ~tdi_out, t);
    for (int i = 0; i < n; i++) begin
      pulse(i == n - 1, din[i], t);
      dout[i] = t;
    end
    pulse(1'b1, ~tdi_out, t);
    pulse(1'b0, ~tdi_out, t);
  endtask
endmodule
`default_nettype wire

// [verif/test_jtbs_top.sv]
`timescale 1ns/1ps
`default_nettype none
module test_jtbs_top;
  logic clk = 1'b0;
  logic rst_b, tck, tms, tdi, tdo, tdo_oe_n, ext, cont;
  logic [74:0] core_v, pin_v, pin_o, hiz, got, u;
  logic [2:0] insn;
  logic [3:0] state;
  integer seed = 89601;
  int n_errors = 0;
  int checked = 0;

  always #12.5 clk = ~clk;

  jtbs_top dut (
    .clock_in(clk), .rst_b_in(rst_b), .tck_in(tck), .tms_in(tms),
    .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n),
    .core_out_in(core_v), .pin_in(pin_v), .pin_out(pin_o),
    .pad_hiz_out(hiz), .extest_active_out(ext),
    .continuity_mode_out(cont), .test_instruction_out(insn),
    .tap_state_out(state)
  );
  jtbs_tap_host u_host (
    .tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo),
    .tdo_oe_n_in(tdo_oe_n)
  );
  // ====
  // helpers
  function automatic logic [74:0] rnd();
    logic [95:0] w;
    w = {$random(seed), $random(seed), $random(seed)};
    return w[74:0];
  endfunction
  function automatic logic [74:0] rev(input logic [74:0] v);
    for (int i = 0; i < 75; i++) rev[i] = v[74 - i];
  endfunction
  function automatic logic [74:0] hiz_exp(input logic [2:0] c);
    return (c == 3'h5) ? {12'h000, {63{1'b1}}} : 75'h0;
  endfunction
  task automatic check(input string what, input logic [74:0] e,
                       input logic [74:0] s);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic load_ir(input logic [2:0] code);
    @(negedge clk);
    u_host.scan(1'b1, 3, {72'h0, code}, got);
    repeat (8) @(negedge clk);
  endtask
  // ====
  // run cap
  initial begin
    #2000000;
    n_errors++;
    report_and_stop();
  end
  // ====
  // main sequence
  initial begin
    rst_b = 1'b0;
    core_v = rnd();
    pin_v = rnd();
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    check("insn", 75'h7, {72'h0, insn});
    check("state", 75'h0, {71'h0, state});
    check("oe_n", 75'h1, {74'h0, tdo_oe_n});
    u_host.to_idle();
    @(negedge clk);
    core_v = rnd();
    @(negedge clk);
    check("pins", core_v, pin_o);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      load_ir(c[2:0]);
      check("ir capture", 75'h1, {72'h0, got[2:0]});
      check("insn", {72'h0, c[2:0]}, {72'h0, insn});
      check("extest", {74'h0, c == 0}, {74'h0, ext});
      check("cont", {74'h0, c == 6}, {74'h0, cont});
      check("hiz", hiz_exp(c[2:0]), hiz);
      if (c > 1) begin
        @(negedge clk);
        u = rnd();
        u_host.scan(1'b0, 20, {55'h0, u[19:0]}, got);
        check("bypass", {55'h0, u[18:0], 1'b0}, got);
        check("pins", core_v, pin_o);
      end
    end
    $display("test instruction codes done");
    load_ir(3'h1);
    @(negedge clk);
    pin_v = rnd();
    u = rnd();
    repeat (4) @(negedge clk);
    u_host.scan(1'b0, 75, rev(u), got);
    check("capture", pin_v, rev(got));
    check("pins", core_v, pin_o);
    load_ir(3'h0);
    check("extest pins", u, pin_o);
    $display("test boundary chain done");
    rst_b = 1'b0;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    check("insn", 75'h7, {72'h0, insn});
    check("pins", core_v, pin_o);
    $display("test second reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
